// >>> sra_defs.vh
`ifndef SRA_DEFS_VH
`define SRA_DEFS_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define SRA_OFF_VERSION 12'h000
`define SRA_OFF_ROM_ACCESS 12'h004

// ----------------------------------------
// Version register fields
// ----------------------------------------
`define SRA_VER_MAJOR 8'h01
`define SRA_VER_MINOR 8'h10
`define SRA_VER_PRESENT_BIT 24

// ----------------------------------------
// Serial ROM access register fields
// ----------------------------------------
`define SRA_ROM_CLEAR_BIT 31
`define SRA_ROM_GO_BIT 25
`define SRA_OPT_PTR_VALUE 8'h20
`define SRA_OPT_PTR_NONE 8'h00
`define SRA_OPT_BYTE_ADDR 8'h06
`define SRA_OPT_FLAG_BIT 5

// ----------------------------------------
// Boot load and serial ROM link
// ----------------------------------------
`define SRA_NODE_INFO_BYTES 20
`define SRA_ROM_DEV_ADDR 7'h50
`define SRA_PCLK_MHZ 25
`define SRA_QUARTER_NS 2500
`define SRA_QUARTER_CYC ((`SRA_QUARTER_NS * `SRA_PCLK_MHZ + 999) / 1000)
`define SRA_LAST_STEP 6'd38

`endif

// >>> sra_regs_sva.sv
`timescale 1ns/1ns
`default_nettype none
module sra_regs_sva #(
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rom_sda_out,
  input wire logic node_info_valid_q,
  input wire logic node_info_done_q
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_rd_ver; pready && !pwrite && paddr == 12'h000; endsequence
  sequence s_rd_acc; pready && !pwrite && paddr == 12'h004; endsequence
  a_ready_next: assert property (s_setup |=> pready) else $error("no pready after setup");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
  a_ready_cause: assert property (pready |-> $past(psel && !penable)) else $error("stray pready");
  a_err_unmapped: assert property (pready |-> pslverr == (paddr != 12'h000 && paddr != 12'h004))
    else $error("pslverr wrong");
  a_ver_fixed: assert property (s_rd_ver |-> prdata[31:25] == 7'h00 && prdata[23:0] == 24'h010010)
    else $error("version word wrong");
  a_acc_zeros: assert property (s_rd_acc |-> prdata[30:26] == 5'h00 && !prdata[24] && prdata[15:8] == 8'h00)
    else $error("reserved bits set");
  a_opt_ptr: assert property (s_rd_acc |-> prdata[7:0] == 8'h00 || prdata[7:0] == 8'h20)
    else $error("option pointer wrong");
  a_rdata_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata)) else $error("prdata moved");
  a_done_sticky: assert property (node_info_done_q |=> node_info_done_q)
    else $error("boot done dropped");
  a_byte_pulse: assert property (node_info_valid_q |=> !node_info_valid_q)
    else $error("boot byte pulse long");
  a_sda_low_only: assert property (rom_sda_out == 1'b0) else $error("data line driven high");
endmodule // sra_regs_sva
bind sra_serial_rom_access_regs sra_regs_sva #(.ADDR_W(ADDR_W)) i_sra_regs_sva (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .rom_sda_out(rom_sda_out), .node_info_valid_q(node_info_valid_q),
  .node_info_done_q(node_info_done_q));
`default_nettype wire

// >>> sra_rom_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----
// Serial ROM, random read
// ----
module sra_rom_model #(
  parameter logic [6:0] DEV_ADDR = 7'h50
) (
  input wire logic scl,
  input wire logic sda,
  input wire logic present,
  output var logic pull_q
);
  logic [7:0] mem [0:255];
  logic [7:0] sh, ptr;
  logic rd;
  int bc, ph;
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'ha5;
    pull_q = 1'b0;
    bc = 0;
    ph = 3;
    ptr = 8'h00;
    rd = 1'b0;
    sh = 8'h00;
  end
  // Start and stop seen with clock high
  always @(negedge sda) if (scl === 1'b1) begin
    bc = 0;
    ph = 0;
  end
  always @(posedge sda) if (scl === 1'b1) ph = 3;
  always @(posedge scl) begin
    if (bc < 8 && ph < 2) sh = {sh[6:0], sda};
    bc = bc + 1;
  end
  always @(negedge scl) begin
    if (bc == 8 && ph == 0) begin
      rd = sh[0];
      pull_q = present && sh[7:1] == DEV_ADDR;
      if (!pull_q) ph = 3;
    end else if (bc == 8 && ph == 1) begin
      ptr = sh;
      pull_q = 1'b1;
    end else if (bc == 8 && ph == 2) begin
      pull_q = 1'b0;
      ptr = ptr + 8'h01;
    end else if (bc == 9 && ph < 3) begin
      bc = 0;
      ph = (ph == 0) ? (rd ? 2 : 1) : 3;
      pull_q = (ph == 2) ? !mem[ptr][7] : 1'b0;
    end else if (ph == 2 && bc < 8) begin
      pull_q = !mem[ptr][7 - bc];
    end
  end
endmodule // sra_rom_model
`default_nettype wire

// >>> sra_rom_reader.v
`timescale 1ns/1ns
`default_nettype none
`include "sra_defs.vh"

module sra_rom_reader #(
  parameter QCYC = `SRA_QUARTER_CYC,
  parameter [6:0] DEV_ADDR = `SRA_ROM_DEV_ADDR
) (
  input wire pclk,
  input wire presetn,
  input wire start,
  input wire [7:0] addr,
  input wire sda_in,
  output reg busy_q,
  output reg done_q,
  output reg nack_q,
  output reg [7:0] data_q,
  output reg scl_q,
  output reg sda_out_q,
  output reg sda_oe_q
);

  // ----------------------------------------
  // Step sequencer: four quarters per step
  // ----------------------------------------
  reg [7:0] div_q;
  reg [1:0] qtr_q;
  reg [5:0] step_q;
  reg [7:0] addr_q;
  wire tick = (div_q == QCYC[7:0] - 8'd1);

  reg is_start;
  reg is_stop;
  reg is_ack;
  reg is_rx;
  reg is_nack;
  reg [7:0] tx_byte;
  reg [2:0] bit_idx;
  reg [5:0] idx_diff;
  reg drv_val;
  reg scl_val;

  always @* begin
    is_start = (step_q == 6'd0) || (step_q == 6'd19);
    is_stop = (step_q == `SRA_LAST_STEP);
    is_ack = (step_q == 6'd9) || (step_q == 6'd18) || (step_q == 6'd28);
    is_rx = (step_q >= 6'd29) && (step_q <= 6'd36);
    is_nack = (step_q == 6'd37);
    tx_byte = addr_q;
    idx_diff = 6'd0;
    if (step_q <= 6'd8) begin
      tx_byte = {DEV_ADDR, 1'b0};
      idx_diff = 6'd8 - step_q;
    end else if (step_q <= 6'd17) begin
      idx_diff = 6'd17 - step_q;
    end else if (step_q <= 6'd27) begin
      tx_byte = {DEV_ADDR, 1'b1};
      idx_diff = 6'd27 - step_q;
    end
    // Only the bit position within the byte matters
    bit_idx = idx_diff[2:0];
    if (is_start) begin
      drv_val = (qtr_q < 2'd2);
      scl_val = (qtr_q == 2'd1) || (qtr_q == 2'd2);
    end else if (is_stop) begin
      drv_val = (qtr_q >= 2'd2);
      scl_val = (qtr_q != 2'd0);
    end else begin
      drv_val = (is_ack || is_rx || is_nack) ? 1'b1 : tx_byte[bit_idx];
      scl_val = (qtr_q == 2'd1) || (qtr_q == 2'd2);
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 8'h00;
      qtr_q <= 2'd0;
      step_q <= 6'd0;
      addr_q <= 8'h00;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      nack_q <= 1'b0;
      data_q <= 8'h00;
      scl_q <= 1'b1;
      sda_out_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      sda_out_q <= 1'b0;
      if (!busy_q) begin
        scl_q <= 1'b1;
        sda_oe_q <= 1'b0;
        if (start) begin
          busy_q <= 1'b1;
          addr_q <= addr;
          nack_q <= 1'b0;
          div_q <= 8'h00;
          qtr_q <= 2'd0;
          step_q <= 6'd0;
        end
      end else begin
        scl_q <= scl_val;
        // Open drain: drive only a low
        sda_oe_q <= ~drv_val;
        div_q <= tick ? 8'h00 : div_q + 8'd1;
        if (tick) begin
          qtr_q <= qtr_q + 2'd1;
          if (qtr_q == 2'd2 && is_ack && sda_in) begin
            nack_q <= 1'b1;
          end
          if (qtr_q == 2'd2 && is_rx) begin
            data_q <= {data_q[6:0], sda_in};
          end
          if (qtr_q == 2'd3) begin
            step_q <= step_q + 6'd1;
            if (is_stop) begin
              busy_q <= 1'b0;
              done_q <= 1'b1;
            end
          end
        end
      end
    end
  end

endmodule // sra_rom_reader

`default_nettype wire

// >>> sra_serial_rom_access_regs.v
// Design decision made here: the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "sra_defs.vh"

// Functional notes
// - Version bit 24 shows 1 when the serial ROM answered, else 0.
// - With the ROM present, node information bytes load after hardware reset.
// - Version field bits 23..16 read major value 01h.
// - Revision field bits 7..0 read minor value 10h.
// - Other version bits read zero; writes to that register do nothing.
// - Writing 1 to bit 31 resets the ROM byte pointer to zero.
// - The address-clear bit drops to 0 once the pointer reset is done.
// - Pointer reset leaves the read-data field untouched.
// - Writing 1 to bit 25 reads the byte at the current pointer.
// - The read-start bit drops to 0 when that byte read completes.
// - The fetched byte shows in read-only bits 23..16.
// - Option ROM pointer reads zero by default.
// - ROM byte 6h bit 5 set makes the option ROM pointer read 20h.
// - Bits 30..26, 24 and 15..8 of the access register read zero.
module sra_serial_rom_access_regs #(
  parameter ADDR_W = 12,
  parameter NODE_INFO_BYTES = `SRA_NODE_INFO_BYTES,
  parameter QCYC = `SRA_QUARTER_CYC,
  // Arbitrary default device address
  parameter [6:0] DEV_ADDR = `SRA_ROM_DEV_ADDR
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output wire rom_scl,
  output wire rom_sda_out,
  output wire rom_sda_oe,
  input wire rom_sda_in,
  output reg node_info_valid_q,
  output reg [7:0] node_info_index_q,
  output reg [7:0] node_info_byte_q,
  output reg node_info_done_q
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [3:0] ST_BOOT_GO = 4'b0001;
  localparam [3:0] ST_BOOT_WAIT = 4'b0010;
  localparam [3:0] ST_IDLE = 4'b0100;
  localparam [3:0] ST_READ_WAIT = 4'b1000;
  // Index of the last boot byte
  localparam [31:0] LAST_IDX = NODE_INFO_BYTES - 1;

  reg [3:0] state_q;
  reg [7:0] ptr_q;
  reg [7:0] boot_idx_q;
  reg present_q;
  reg opt_rom_q;
  reg clear_q;
  reg go_q;
  reg [7:0] rd_byte_q;
  reg eng_start_q;
  reg [7:0] eng_addr_q;

  wire eng_busy;
  wire eng_done;
  wire eng_nack;
  wire [7:0] eng_data;

  // ----------------------------------------
  // Data pin synchroniser
  // ----------------------------------------
  reg sda_s1_q;
  reg sda_s2_q;
  reg sda_s3_q;
  reg sda_f_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
      sda_f_q <= 1'b1;
    end else begin
      sda_s1_q <= rom_sda_in;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
      if (sda_s2_q == sda_s3_q) begin
        sda_f_q <= sda_s3_q;
      end
    end
  end

  // ----------------------------------------
  // Serial ROM byte reader
  // ----------------------------------------
  sra_rom_reader #(
    .QCYC(QCYC),
    .DEV_ADDR(DEV_ADDR)
  ) u_reader (
    .pclk(pclk),
    .presetn(presetn),
    .start(eng_start_q),
    .addr(eng_addr_q),
    .sda_in(sda_f_q),
    .busy_q(eng_busy),
    .done_q(eng_done),
    .nack_q(eng_nack),
    .data_q(eng_data),
    .scl_q(rom_scl),
    .sda_out_q(rom_sda_out),
    .sda_oe_q(rom_sda_oe)
  );

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire setup = psel & ~penable;
  wire access = psel & penable & pready;
  wire hit_ver = (paddr == `SRA_OFF_VERSION);
  wire hit_rom = (paddr == `SRA_OFF_ROM_ACCESS);
  wire wr_rom = access & pwrite & hit_rom;
  wire set_clear = wr_rom & pwdata[`SRA_ROM_CLEAR_BIT];
  wire set_go = wr_rom & pwdata[`SRA_ROM_GO_BIT];

  reg [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h0000_0000;
    if (hit_ver) begin
      rd_mux = {7'h00, present_q, `SRA_VER_MAJOR, 8'h00, `SRA_VER_MINOR};
    end else if (hit_rom) begin
      rd_mux = {clear_q, 5'h00, go_q, 1'b0, rd_byte_q, 8'h00,
                (opt_rom_q ? `SRA_OPT_PTR_VALUE : `SRA_OPT_PTR_NONE)};
    end
  end

  // One wait-free access phase per transfer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup & ~hit_ver & ~hit_rom;
      if (setup && !pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  reg hw_clear_clr;
  reg hw_go_clr;

  always @* begin
    hw_clear_clr = (state_q == ST_IDLE) && clear_q;
    hw_go_clr = (state_q == ST_READ_WAIT) && eng_done;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_BOOT_GO;
      ptr_q <= 8'h00;
      boot_idx_q <= 8'h00;
      present_q <= 1'b0;
      opt_rom_q <= 1'b0;
      clear_q <= 1'b0;
      go_q <= 1'b0;
      rd_byte_q <= 8'h00;
      eng_start_q <= 1'b0;
      eng_addr_q <= 8'h00;
      node_info_valid_q <= 1'b0;
      node_info_index_q <= 8'h00;
      node_info_byte_q <= 8'h00;
      node_info_done_q <= 1'b0;
    end else begin
      eng_start_q <= 1'b0;
      node_info_valid_q <= 1'b0;
      // Software set wins over hardware clear
      clear_q <= set_clear | (clear_q & ~hw_clear_clr);
      // Software set wins over hardware clear
      go_q <= set_go | (go_q & ~hw_go_clr);
      case (state_q)
        ST_BOOT_GO: begin
          eng_start_q <= 1'b1;
          eng_addr_q <= boot_idx_q;
          state_q <= ST_BOOT_WAIT;
        end
        ST_BOOT_WAIT: begin
          if (eng_done) begin
            if (eng_nack) begin
              node_info_done_q <= 1'b1;
              state_q <= ST_IDLE;
            end else begin
              present_q <= 1'b1;
              node_info_valid_q <= 1'b1;
              node_info_index_q <= boot_idx_q;
              node_info_byte_q <= eng_data;
              if (boot_idx_q == `SRA_OPT_BYTE_ADDR) begin
                opt_rom_q <= eng_data[`SRA_OPT_FLAG_BIT];
              end
              if (boot_idx_q == LAST_IDX[7:0]) begin
                node_info_done_q <= 1'b1;
                state_q <= ST_IDLE;
              end else begin
                boot_idx_q <= boot_idx_q + 8'd1;
                state_q <= ST_BOOT_GO;
              end
            end
          end
        end
        ST_IDLE: begin
          if (clear_q) begin
            ptr_q <= 8'h00;
          end else if (go_q) begin
            eng_start_q <= 1'b1;
            eng_addr_q <= ptr_q;
            state_q <= ST_READ_WAIT;
          end
        end
        ST_READ_WAIT: begin
          if (eng_done) begin
            if (!eng_nack) begin
              rd_byte_q <= eng_data;
            end
            ptr_q <= ptr_q + 8'd1;
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // sra_serial_rom_access_regs

`default_nettype wire

// >>> sra_serial_rom_access_regs_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module sra_serial_rom_access_regs_tb_top;
  logic pclk, presetn, psel, penable, pwrite, present, pready, pslverr, scl, sda_out, sda_oe, pull, nv, nd, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [7:0] ni, nb;
  int fails, checks_done, nbytes;
  wire logic sda_line = !(sda_oe || pull);
  sra_serial_rom_access_regs #(.NODE_INFO_BYTES(8), .QCYC(3)) i_sra_serial_rom_access_regs (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rom_scl(scl), .rom_sda_out(sda_out),
    .rom_sda_oe(sda_oe), .rom_sda_in(sda_line), .node_info_valid_q(nv), .node_info_index_q(ni),
    .node_info_byte_q(nb), .node_info_done_q(nd));
  sra_rom_model i_sra_rom_model (.scl(scl), .sda(sda_line), .present(present), .pull_q(pull));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_clear(input int b);
    int n;
    n = 0;
    do begin apb(1'b0, 12'h004, 32'h0); n++; end while (r[b] !== 1'b0 && n < 400);
  endtask
  task automatic do_reset(input logic p);
    int n;
    n = 0;
    present <= p;
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    nbytes = 0;
    while (nd !== 1'b1 && n < 8000) begin @(posedge pclk); n++; end
  endtask
  // Boot bytes follow the ROM fill pattern
  always @(posedge pclk) if (nv === 1'b1) begin
    nbytes++;
    chk(nb, ni ^ 8'ha5);
  end
  task automatic t_regs();
    apb(1'b0, 12'h000, 32'h0); chk(r, 32'h0101_0010);
    apb(1'b1, 12'h000, 32'hffff_ffff);
    apb(1'b0, 12'h000, 32'h0); chk(r, 32'h0101_0010);
    apb(1'b0, 12'h008, 32'h0); chk({e, r}, {1'b1, 32'h0});
    chk(nbytes, 8);
    apb(1'b0, 12'h004, 32'h0); chk({r[31:24], r[15:0]}, 24'h000020);
  endtask
  task automatic t_cmds();
    apb(1'b1, 12'h004, 32'h8000_0000); wait_clear(31);
    apb(1'b1, 12'h004, 32'h0200_0000);
    apb(1'b0, 12'h004, 32'h0); chk(r[25], 1);
    wait_clear(25); chk(r[23:16], 8'ha5);
    apb(1'b1, 12'h004, 32'h0200_0000); wait_clear(25); chk(r[23:16], 8'ha4);
    apb(1'b1, 12'h004, 32'h8000_0000); wait_clear(31); chk(r[23:16], 8'ha4);
    apb(1'b1, 12'h004, 32'h8200_0000); wait_clear(25); chk(r[31:16], 16'h00a5);
  endtask
  task automatic t_absent();
    do_reset(1'b0);
    apb(1'b0, 12'h000, 32'h0); chk(r, 32'h0001_0010);
    apb(1'b0, 12'h004, 32'h0); chk(r[7:0], 8'h00);
    chk(nbytes, 0);
  endtask
  task automatic tally_and_finish();
    if (fails == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    presetn = 1'b0;
    present = 1'b1;
    fails = 0;
    checks_done = 0;
    nbytes = 0;
    do_reset(1'b1);
    t_regs();
    t_cmds();
    t_absent();
    tally_and_finish();
  end
  // Two boots and three ROM reads need about 6000 cycles
  initial begin
    #2000000;
    fails++;
    tally_and_finish();
  end
endmodule // sra_serial_rom_access_regs_tb_top
`default_nettype wire
